// ---- shared/flash_self_prog_pkg.sv ----
// package for the flash self-programming table access block
// assumes a 125 MHz core clock and an apb master on the same clock
package flash_self_prog_pkg;

  // ****************************************
  // register map (byte addresses, one word each)
  // ****************************************
  localparam int PADDR_W = 8; // apb address width
  localparam logic [7:0] OFS_PTR_LOW = 8'h00; // table_pointer_low
  localparam logic [7:0] OFS_PTR_HIGH = 8'h04; // table_pointer_high
  localparam logic [7:0] OFS_PTR_UPPER = 8'h08; // table_pointer_upper
  localparam logic [7:0] OFS_LATCH = 8'h0C; // table_latch
  localparam logic [7:0] OFS_CTRL = 8'h10; // memory_control_reg
  localparam logic [7:0] OFS_UNLOCK = 8'h14; // unlock_port
  localparam logic [7:0] OFS_TABLE_OP = 8'h18; // table operation command
  localparam logic [7:0] OFS_STATUS = 8'h1C; // done flag and busy

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_PROG_SEL = 7; // program_space_select
  localparam int CTRL_CFG_SEL = 6; // config_space_select
  localparam int CTRL_ERASE_EN = 4; // row erase enable
  localparam int CTRL_ABORT = 3; // write_abort_flag
  localparam int CTRL_PERMIT = 2; // write_permit
  localparam int CTRL_START = 1; // start bit
  localparam int OP_MODE_LSB = 0; // pointer update mode, 2 bits
  localparam int OP_WRITE = 2; // 1 = table_write_op, 0 = table_read_op
  localparam int STAT_DONE = 0; // write_done_flag, write one to clear
  localparam int STAT_BUSY = 1; // long write running

  // ****************************************
  // sizes, keys and reset values
  // ****************************************
  localparam int PTR_W = 22; // full table pointer
  localparam int PTR_LOW_W = 21; // part touched by auto update
  localparam int ROW_LSB = 6; // row field is pointer 21..6
  localparam int ROW_W = 16;
  localparam int HOLD_COUNT = 32; // holding registers
  localparam int HOLD_IDX_W = 5;
  localparam logic [7:0] HOLD_RESET = 8'hFF; // erased-byte pattern
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
  localparam logic [PTR_W-1:0] PTR_RESET = 22'h000000;
  localparam logic [7:0] LATCH_RESET = 8'h00;
  localparam logic ABORT_RESET = 1'b1; // a reset may have cut a write short

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int PROG_TIME_NS = 2000000; // about 2 ms per long write
  localparam int PROG_TIME_CYCLES = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int TIMER_W = 18;

  // ****************************************
  // enumerations
  // ****************************************
  typedef enum logic [1:0] {
    MODE_KEEP = 2'h0,
    MODE_POST_INC = 2'h1,
    MODE_POST_DEC = 2'h2,
    MODE_PRE_INC = 2'h3
  } ptr_mode_e;

  typedef enum logic [2:0] {
    FSM_IDLE = 3'h1,
    FSM_READ = 3'h2,
    FSM_LONG = 3'h4
  } seq_state_e;

  typedef enum logic [2:0] {
    UNL_IDLE = 3'h1,
    UNL_HALF = 3'h2,
    UNL_ARMED = 3'h4
  } unlock_state_e;

endpackage

// ---- hdl/hold_byte.sv ----
// one byte-wide holding register for the programming block buffer
// assumes load and preset come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module hold_byte
  import flash_self_prog_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic load_in,
  input wire logic preset_in,
  input wire logic [7:0] data_in,
  output logic [7:0] value_out
);

  typedef struct packed {
    logic [7:0] value;  // stored byte
  } hold_state_s;

  hold_state_s state_reg;
  hold_state_s state_next;

  // ****************************************
  // next value
  // ****************************************
  // preset wins: it fires only after a long write, when no load occurs
  always_comb begin
    state_next = state_reg;
    if (preset_in) begin
      state_next.value = HOLD_RESET;
    end else if (load_in) begin
      state_next.value = data_in;
    end
  end

  // ****************************************
  // storage
  // ****************************************
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg.value <= HOLD_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign value_out = state_reg.value;

endmodule
`default_nettype wire

// ---- hdl/flash_self_program_table_access.sv ----
// table pointer, table latch, holding buffer and long-write sequencer for
// self-programming of on-chip program flash, reached over apb.
// assumes the array answers flash_addr_out within the same cycle (the
// address is registered) and clears bits only when programmed.
//
// What this block does
// - three pointer bytes form 22-bit address
// - low 21 bits memory, top bit config
// - four pointer update modes per access
// - auto update touches low 21 bits only
// - table read loads addressed byte into latch
// - pointer bit zero picks word byte
// - table write fills holding register by bits 4..0
// - pointer bits 21..6 choose programmed block
// - erase uses bits 21..6, ignores 5..0
// - only whole 64-byte row erase
// - program select, permit, erase enable give erase
// - 55h then AAh before start
// - long write stalls core about 2 ms
// - internal timer ends long write
// - programming only in 32-byte blocks
// - table writes short; control write starts long
// - holding registers FFh at reset, after program
// - FFh bytes leave array unchanged
// - partial buffer load still programs
// - start set-only, hardware clears, done flag
// - abort flag on cut or improper start
// - unlock port stores nothing, reads zero
// - write permit clear after reset
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_table_access
  import flash_self_prog_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = PROG_TIME_CYCLES  // long write length in clocks
)
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // apb slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [PADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // flash array side
  output logic [PTR_W-1:0] flash_addr_out,
  input wire logic [15:0] flash_rdata_in,
  output logic flash_erase_out,
  output logic flash_program_out,
  output logic [ROW_W-1:0] flash_row_out,
  output logic [8*HOLD_COUNT-1:0] flash_block_data_out,
  // core side
  output logic cpu_stall_out,
  output logic write_done_flag_out
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    seq_state_e seq;                   // sequencer state
    unlock_state_e unlock;             // unlock tracker
    logic [PTR_W-1:0] table_pointer;   // upper:high:low joined
    logic [7:0] table_latch;           // byte moved by table ops
    logic program_space_select;
    logic config_space_select;
    logic row_erase_enable;
    logic write_abort_flag;
    logic write_permit;
    logic start;                       // long write running
    logic write_done_flag;             // sticky completion flag
    logic erase_op;                    // current long write is an erase
    logic [TIMER_W-1:0] timer;         // remaining long write cycles
    logic [ROW_W-1:0] row;             // captured row address
    logic [PTR_W-1:0] flash_addr;      // address shown to the array
  } seq_state_s;

  seq_state_s state_reg;
  seq_state_s state_next;

  logic xfer;                          // apb access completes this edge
  logic wr;                            // completing write
  logic mapped;                        // address hits a register
  logic [PTR_W-1:0] ptr_inc;           // pointer plus one, low part only
  logic [PTR_W-1:0] ptr_dec;           // pointer minus one, low part only
  logic [PTR_W-1:0] ptr_eff;           // pointer used by this table op
  ptr_mode_e op_mode;                  // requested update mode
  logic [HOLD_COUNT-1:0] hold_load;    // one-hot holding register load
  logic hold_preset;                   // refill buffer with FFh
  logic [7:0] word_byte;               // byte picked from the array word
  logic start_ok;                      // start request may run

  // ****************************************
  // apb decode
  // ****************************************
  // ready unless a long write or table read runs, so a long write
  // holds off the core's next bus access until it ends
  assign pready_out = (state_reg.seq == FSM_IDLE);
  assign xfer = psel_in & penable_in & pready_out;
  assign wr = xfer & pwrite_in;
  assign op_mode = ptr_mode_e'(pwdata_in[OP_MODE_LSB +: 2]);

  always_comb begin
    mapped = 1'b1;
    case (paddr_in)
      OFS_PTR_LOW, OFS_PTR_HIGH, OFS_PTR_UPPER, OFS_LATCH: mapped = 1'b1;
      OFS_CTRL, OFS_UNLOCK, OFS_TABLE_OP, OFS_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // unmapped addresses answer with an error and read as zero
  assign pslverr_out = psel_in & penable_in & pready_out & ~mapped;

  // ****************************************
  // read mux
  // ****************************************
  always_comb begin
    prdata_out = 32'h00000000;
    if (psel_in & ~pwrite_in) begin
      case (paddr_in)
        OFS_PTR_LOW: prdata_out[7:0] = state_reg.table_pointer[7:0];
        OFS_PTR_HIGH: prdata_out[7:0] = state_reg.table_pointer[15:8];
        OFS_PTR_UPPER: prdata_out[5:0] = state_reg.table_pointer[21:16];
        OFS_LATCH: prdata_out[7:0] = state_reg.table_latch;
        OFS_CTRL: begin
          prdata_out[CTRL_PROG_SEL] = state_reg.program_space_select;
          prdata_out[CTRL_CFG_SEL] = state_reg.config_space_select;
          prdata_out[CTRL_ERASE_EN] = state_reg.row_erase_enable;
          prdata_out[CTRL_ABORT] = state_reg.write_abort_flag;
          prdata_out[CTRL_PERMIT] = state_reg.write_permit;
          prdata_out[CTRL_START] = state_reg.start;
        end
        OFS_STATUS: begin
          prdata_out[STAT_DONE] = state_reg.write_done_flag;
          prdata_out[STAT_BUSY] = state_reg.start;
        end
        default: prdata_out = 32'h00000000;  // unlock port included
      endcase
    end
  end

  // ****************************************
  // pointer arithmetic
  // ****************************************
  // only the low 21 bits wrap; the space bit stays as software left it
  assign ptr_inc = {state_reg.table_pointer[PTR_W-1],
                    state_reg.table_pointer[PTR_LOW_W-1:0] + 21'h000001};
  assign ptr_dec = {state_reg.table_pointer[PTR_W-1],
                    state_reg.table_pointer[PTR_LOW_W-1:0] - 21'h000001};
  assign ptr_eff = (op_mode == MODE_PRE_INC) ? ptr_inc : state_reg.table_pointer;

  // the array hands a 16-bit word; the low address bit picks the byte
  assign word_byte = state_reg.flash_addr[0] ? flash_rdata_in[15:8] :
                     flash_rdata_in[7:0];

  // a start runs only right after the unlock pair, with a prior
  // permit and a flash space selected
  assign start_ok = (state_reg.unlock == UNL_ARMED) & state_reg.write_permit &
                    (state_reg.program_space_select | state_reg.config_space_select);

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    state_next = state_reg;
    hold_load = '0;
    hold_preset = 1'b0;

    // unlock tracker: any other access drops it; a repeated 55h keeps the first half
    if (xfer) begin
      case (state_reg.unlock)
        UNL_IDLE: begin
          if (wr && paddr_in == OFS_UNLOCK && pwdata_in[7:0] == UNLOCK_KEY1) begin
            state_next.unlock = UNL_HALF;
          end
        end
        UNL_HALF: begin
          if (wr && paddr_in == OFS_UNLOCK && pwdata_in[7:0] == UNLOCK_KEY2) begin
            state_next.unlock = UNL_ARMED;
          end else if (wr && paddr_in == OFS_UNLOCK && pwdata_in[7:0] == UNLOCK_KEY1) begin
            state_next.unlock = UNL_HALF;
          end else begin
            state_next.unlock = UNL_IDLE;
          end
        end
        UNL_ARMED: state_next.unlock = UNL_IDLE;  // one access consumes it
        default: state_next.unlock = UNL_IDLE;
      endcase
    end

    // register writes
    if (wr) begin
      case (paddr_in)
        OFS_PTR_LOW: state_next.table_pointer[7:0] = pwdata_in[7:0];
        OFS_PTR_HIGH: state_next.table_pointer[15:8] = pwdata_in[7:0];
        OFS_PTR_UPPER: state_next.table_pointer[21:16] = pwdata_in[5:0];
        OFS_LATCH: state_next.table_latch = pwdata_in[7:0];
        OFS_CTRL: begin
          state_next.program_space_select = pwdata_in[CTRL_PROG_SEL];
          state_next.config_space_select = pwdata_in[CTRL_CFG_SEL];
          state_next.row_erase_enable = pwdata_in[CTRL_ERASE_EN];
          state_next.write_abort_flag = pwdata_in[CTRL_ABORT];
          state_next.write_permit = pwdata_in[CTRL_PERMIT];
          // a zero written to start is ignored: software can only set it
          if (pwdata_in[CTRL_START]) begin
            if (start_ok) begin
              // the control write is the only way into a long write
              state_next.start = 1'b1;
              state_next.seq = FSM_LONG;
              state_next.erase_op = state_reg.program_space_select &
                                    state_reg.write_permit &
                                    state_reg.row_erase_enable;
              state_next.row = state_reg.table_pointer[PTR_W-1:ROW_LSB];
              state_next.timer = TIMER_W'(PROG_CYCLES - 1);
            end else begin
              state_next.write_abort_flag = 1'b1;  // improper start
            end
          end
        end
        OFS_TABLE_OP: begin
          // pointer update for all four modes
          case (op_mode)
            MODE_POST_INC: state_next.table_pointer = ptr_inc;
            MODE_POST_DEC: state_next.table_pointer = ptr_dec;
            MODE_PRE_INC: state_next.table_pointer = ptr_inc;
            default: state_next.table_pointer = state_reg.table_pointer;
          endcase
          if (pwdata_in[OP_WRITE]) begin
            // short write: only the holding register changes, no stall
            hold_load[ptr_eff[HOLD_IDX_W-1:0]] = 1'b1;
          end else begin
            // full 22-bit address, data arrives next cycle
            state_next.flash_addr = ptr_eff;
            state_next.seq = FSM_READ;
          end
        end
        OFS_STATUS: begin
          if (pwdata_in[STAT_DONE]) begin
            state_next.write_done_flag = 1'b0;
          end
        end
        default: state_next.seq = state_reg.seq;  // unlock port keeps no data
      endcase
    end

    // sequencer
    case (state_reg.seq)
      FSM_IDLE: begin
        state_next.timer = state_next.timer;
      end
      FSM_READ: begin
        state_next.table_latch = word_byte;
        state_next.seq = FSM_IDLE;
      end
      FSM_LONG: begin
        // the internal timer ends the operation by itself
        if (state_reg.timer == '0) begin
          state_next.seq = FSM_IDLE;
          state_next.start = 1'b0;
          state_next.write_abort_flag = 1'b0;
          if (state_reg.erase_op) begin
            state_next.row_erase_enable = 1'b0;
          end else begin
            hold_preset = 1'b1;
          end
        end else begin
          state_next.timer = state_reg.timer - 1'b1;
        end
      end
      default: state_next.seq = FSM_IDLE;
    endcase

    // completion set wins over a clear in the same cycle
    if (state_reg.seq == FSM_LONG && state_reg.timer == '0) begin
      state_next.write_done_flag = 1'b1;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  // write_abort_flag comes up set: an async reset may have landed mid write
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      state_reg.seq <= FSM_IDLE;
      state_reg.unlock <= UNL_IDLE;
      state_reg.table_pointer <= PTR_RESET;
      state_reg.table_latch <= LATCH_RESET;
      state_reg.program_space_select <= 1'b0;
      state_reg.config_space_select <= 1'b0;
      state_reg.row_erase_enable <= 1'b0;
      state_reg.write_abort_flag <= ABORT_RESET;
      state_reg.write_permit <= 1'b0;
      state_reg.start <= 1'b0;
      state_reg.write_done_flag <= 1'b0;
      state_reg.erase_op <= 1'b0;
      state_reg.timer <= '0;
      state_reg.row <= '0;
      state_reg.flash_addr <= PTR_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // ****************************************
  // holding buffer
  // ****************************************
  // all 32 bytes go to the array; untouched ones stay FFh and so
  // leave the array as it was, as programming only clears bits
  generate
    for (genvar i = 0; i < HOLD_COUNT; i++) begin : g_hold
      hold_byte u_hold (
        .sys_clk_in(sys_clk_in),
        .reset_in(reset_in),
        .load_in(hold_load[i]),
        .preset_in(hold_preset),
        .data_in(state_reg.table_latch),
        .value_out(flash_block_data_out[8*i +: 8])
      );
    end
  endgenerate

  // ****************************************
  // outputs
  // ****************************************
  assign flash_addr_out = state_reg.flash_addr;
  assign flash_row_out = state_reg.row;
  assign flash_erase_out = state_reg.start & state_reg.erase_op;
  assign flash_program_out = state_reg.start & ~state_reg.erase_op;
  assign cpu_stall_out = state_reg.start;
  assign write_done_flag_out = state_reg.write_done_flag;

endmodule
`default_nettype wire

// ---- test/flash_prog_properties.sv ----
// checker for the flash self-programming block
// sees only the top ports; attached by the bind at the foot
`timescale 1ns/1ps
`default_nettype none
module flash_prog_checker
  import flash_self_prog_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = 20
)
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [PADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [PTR_W-1:0] flash_addr_out,
  input wire logic [15:0] flash_rdata_in,
  input wire logic flash_erase_out,
  input wire logic flash_program_out,
  input wire logic [ROW_W-1:0] flash_row_out,
  input wire logic [8*HOLD_COUNT-1:0] flash_block_data_out,
  input wire logic cpu_stall_out,
  input wire logic write_done_flag_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  // ****************
  // helper logic
  // ****************
  logic acc; // apb transfer taken at this edge
  logic tbl_op; // table command taken
  logic [17:0] cnt_reg; // cycles spent stalled
  assign acc = psel_in & penable_in & pready_out;
  assign tbl_op = acc & pwrite_in & (paddr_in == OFS_TABLE_OP);
  // count stall cycles; 18 bits cover the full timer
  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      cnt_reg <= 18'h0;
    end else if (cpu_stall_out) begin
      cnt_reg <= cnt_reg + 18'h1;
    end else begin
      cnt_reg <= 18'h0;
    end
  end
  // ****************
  // assertions
  // ****************
  AST_STALL_NO_READY: assert property (cpu_stall_out |-> !pready_out)
    else $error("bus answered during long write");
  AST_STALL_ENDS: assert property ($rose(cpu_stall_out) |-> ##[1:1000] !cpu_stall_out)
    else $error("long write never ended");
  AST_STALL_LEN: assert property ($fell(cpu_stall_out) |-> cnt_reg == PROG_CYCLES)
    else $error("long write length wrong");
  AST_DONE_SET: assert property ($fell(cpu_stall_out) |-> ##[0:1] write_done_flag_out)
    else $error("done flag missing");
  AST_ONE_OP: assert property (!(flash_erase_out && flash_program_out))
    else $error("erase and program together");
  AST_ROW_HOLD: assert property (cpu_stall_out && $past(cpu_stall_out) |->
    $stable(flash_row_out))
    else $error("row moved during long write");
  AST_PRESET: assert property ($fell(flash_program_out) |->
    ##[0:2] (flash_block_data_out == {HOLD_COUNT{HOLD_RESET}}))
    else $error("holding not preset");
  AST_UNLOCK_ZERO: assert property (psel_in && !pwrite_in && paddr_in == OFS_UNLOCK |->
    prdata_out == 32'h0)
    else $error("unlock port read nonzero");
  AST_TBL_SHORT: assert property (tbl_op |=> !cpu_stall_out && !flash_program_out)
    else $error("table op started long write");
  AST_READ_WAIT: assert property (tbl_op && !pwdata_in[OP_WRITE] |=>
    !pready_out ##1 pready_out)
    else $error("table read wait wrong");
  COV_ERASE: cover property ($rose(flash_erase_out));
  COV_PROG: cover property ($rose(flash_program_out));
  COV_READ: cover property (tbl_op && !pwdata_in[OP_WRITE]);
endmodule
bind flash_self_program_table_access flash_prog_checker #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .sys_clk_in(sys_clk_in), .reset_in(reset_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
  .pslverr_out(pslverr_out), .flash_addr_out(flash_addr_out),
  .flash_rdata_in(flash_rdata_in), .flash_erase_out(flash_erase_out),
  .flash_program_out(flash_program_out), .flash_row_out(flash_row_out),
  .flash_block_data_out(flash_block_data_out), .cpu_stall_out(cpu_stall_out),
  .write_done_flag_out(write_done_flag_out));
`default_nettype wire

// ---- test/flash_array_model.sv ----
// behavioural program flash array for the bench
// assumes an asynchronous read of the registered address
`timescale 1ns/1ps
`default_nettype none
module flash_array_model
  import flash_self_prog_pkg::*;
(
  input wire logic [PTR_W-1:0] addr_in,
  output logic [15:0] rdata_out
);
  // content is a fixed function of the word address, so the bench predicts it;
  // config space returns the inverse so a lost top bit shows up
  assign rdata_out = {addr_in[8:1] ^ 8'hC3, addr_in[8:1]} ^ {16{addr_in[21]}};
endmodule
`default_nettype wire

// ---- test/tb_flash_self_program_table_access.sv ----
// self-checking bench for the flash self-programming block
// assumes the array model and the bound checker beside the design
`timescale 1ns/1ps
`default_nettype none
module tb_flash_self_program_table_access
  import flash_self_prog_pkg::*;
;
  logic sys_clk = 1'b0; // core clock
  logic reset = 1'b1; // held 4 cycles
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, fl_erase, fl_prog, stall, done;
  logic [21:0] faddr;
  logic [15:0] frdata, row;
  logic [255:0] blk;
  int miscompares = 0;
  int comparisons = 0;
  always #4 sys_clk = ~sys_clk;
  flash_self_program_table_access #(.PROG_CYCLES(20)) u_dut (
    .sys_clk_in(sys_clk), .reset_in(reset), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .flash_addr_out(faddr),
    .flash_rdata_in(frdata), .flash_erase_out(fl_erase), .flash_program_out(fl_prog),
    .flash_row_out(row), .flash_block_data_out(blk), .cpu_stall_out(stall),
    .write_done_flag_out(done));
  flash_array_model u_array (.addr_in(faddr), .rdata_out(frdata));
  // ****************
  // bus and compare tasks
  // ****************
  // one apb transfer; waits for pready with no cycle count of its own
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) @(posedge sys_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input string n, input logic [255:0] seen, input logic [255:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %0h seen %0h", n, exp, seen);
    end
  endtask
  // byte the array model holds at a pointer
  function automatic logic [7:0] exp_byte(input logic [21:0] p);
    logic [15:0] w;
    w = {p[8:1] ^ 8'hC3, p[8:1]} ^ {16{p[21]}};
    return p[0] ? w[15:8] : w[7:0];
  endfunction
  task automatic set_ptr(input logic [21:0] p);
    apb(1'b1, OFS_PTR_LOW, {24'h0, p[7:0]});
    apb(1'b1, OFS_PTR_HIGH, {24'h0, p[15:8]});
    apb(1'b1, OFS_PTR_UPPER, {26'h0, p[21:16]});
  endtask
  task automatic get_ptr(output logic [21:0] p);
    apb(1'b0, OFS_PTR_LOW, 32'h0);
    p[7:0] = rd[7:0];
    apb(1'b0, OFS_PTR_HIGH, 32'h0);
    p[15:8] = rd[7:0];
    apb(1'b0, OFS_PTR_UPPER, 32'h0);
    p[21:16] = rd[5:0];
  endtask
  // unlock then start; control bits are stored before the start write
  task automatic start_long(input logic [31:0] c);
    apb(1'b1, OFS_CTRL, c);
    apb(1'b1, OFS_UNLOCK, 32'h55);
    apb(1'b1, OFS_UNLOCK, 32'hAA);
    apb(1'b1, OFS_CTRL, c | 32'h2);
    repeat (2) @(posedge sys_clk);
    #1;
    chk("stall", stall, 1'b1);
  endtask
  task automatic finish_long();
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("status", rd[1:0], 2'b01);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", rd, 32'h84);
    apb(1'b1, OFS_STATUS, 32'h1);
    #1;
    chk("done", done, 1'b0);
  endtask
  // refused start: abort flag must rise, no stall
  task automatic try_bad(input logic [31:0] pre, input logic brk);
    apb(1'b1, OFS_CTRL, pre);
    apb(1'b1, OFS_UNLOCK, 32'h55);
    if (brk) apb(1'b0, OFS_LATCH, 32'h0);
    apb(1'b1, OFS_UNLOCK, 32'hAA);
    apb(1'b1, OFS_CTRL, pre | 32'h2);
    #1;
    chk("stall", stall, 1'b0);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", rd, pre | 32'h8);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic t_reset();
    apb(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", rd, 32'h08);
    apb(1'b0, OFS_UNLOCK, 32'h0);
    chk("unlock", rd, 32'h0);
    chk("hold", blk, {HOLD_COUNT{HOLD_RESET}});
    apb(1'b0, 8'h40, 32'h0);
    chk("slverr", err, 1'b1);
    $display("test reset done");
  endtask
  // modes across the 21-bit wrap with the top bit set
  task automatic t_ptr();
    logic [1:0] md [5];
    logic [21:0] ra [5];
    logic [21:0] pa [5];
    logic [21:0] p;
    md = '{MODE_POST_INC, MODE_PRE_INC, MODE_POST_DEC, MODE_POST_DEC, MODE_KEEP};
    ra = '{22'h3FFFFF, 22'h200001, 22'h200001, 22'h200000, 22'h3FFFFF};
    pa = '{22'h200000, 22'h200001, 22'h200000, 22'h3FFFFF, 22'h3FFFFF};
    set_ptr(22'h3FFFFF);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, OFS_TABLE_OP, {30'h0, md[i]});
      apb(1'b0, OFS_LATCH, 32'h0);
      chk("latch", rd[7:0], exp_byte(ra[i]));
      get_ptr(p);
      chk("pointer", p, pa[i]);
    end
    $display("test pointer done");
  endtask
  task automatic t_twrite();
    logic [255:0] e;
    e = {HOLD_COUNT{HOLD_RESET}};
    e[55:40] = 16'h3412;
    set_ptr(22'h3FFF05);
    apb(1'b1, OFS_LATCH, 32'h12);
    apb(1'b1, OFS_TABLE_OP, 32'h4);
    apb(1'b1, OFS_LATCH, 32'h34);
    apb(1'b1, OFS_TABLE_OP, 32'h7);
    #1;
    chk("hold", blk, e);
    chk("prog", fl_prog, 1'b0);
    $display("test table write done");
  endtask
  task automatic t_long();
    try_bad(32'h84, 1'b1);
    try_bad(32'h80, 1'b0);
    set_ptr(22'h000A45);
    start_long(32'h84);
    chk("pgm", {fl_erase, fl_prog}, 2'b01);
    chk("row", row, 16'h0029);
    chk("data", blk[55:40], 16'h3412);
    finish_long();
    chk("hold", blk, {HOLD_COUNT{HOLD_RESET}});
    set_ptr(22'h100FFF);
    start_long(32'h94);
    chk("ers", {fl_erase, fl_prog}, 2'b10);
    chk("row", row, 16'h403F);
    finish_long();
    $display("test long write done");
  endtask
  task automatic results();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    t_reset();
    t_ptr();
    t_twrite();
    t_long();
    results();
  end
  // the run needs well under 2000 cycles
  initial begin
    #100000;
    miscompares++;
    results();
  end
endmodule
`default_nettype wire
